/* File: core/osc_pkg.sv */
// constants, field positions and carrier types of the oscillator control block
// assumes a 32-bit AXI4-Lite register bus and 16-bit registers in the low bits
package osc_pkg;
   localparam int ADDR_W = 4;
   localparam int REG_W = 16;
   localparam int SRC_W = 3;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h8;
   // oscillator_control field positions
   localparam int B_SWITCH_EN = 0;
   localparam int B_SECONDARY_OSCILLATOR_EN = 1;
   localparam int B_SECONDARY_OSCILLATOR_DRV = 2;
   localparam int B_CLK_FAIL = 3;
   localparam int B_PLL_LOCK = 5;
   localparam int B_SEL_LOCK = 7;
   localparam int B_NEW_SRC_LO = 8;
   localparam int B_CUR_SRC_LO = 12;
   localparam int NUM_EVT = 3;
   // interrupt status layout
   localparam int E_SW_DONE = 0;
   localparam int E_CLK_FAIL = 1;
   localparam int E_PLL_LOCK = 2;
   localparam logic [NUM_EVT-1:0] EVT_RESET = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // source codes that run through the pll
   localparam logic [SRC_W-1:0] SRC_PLL_A = 3'h1;
   localparam logic [SRC_W-1:0] SRC_PLL_B = 3'h3;

   typedef enum logic [0:0] {SW_IDLE, SW_BUSY} osc_sw_e;

   // one register write as presented by the bus slave
   typedef struct packed {
      logic en;
      logic [ADDR_W-1:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } osc_wr_s;

   // pll and monitor status coming from the far side
   typedef struct packed {
      logic pll_enabled;
      logic pll_locked;
      logic pll_timer_done;
      logic fail_detect;
   } osc_stat_s;
endpackage

/* File: core/osc_axil_slave.sv */
// AXI4-Lite slave front end: one write and one read in flight
// assumes the register decode answers combinationally on wr_ok/rd_ok/rd_data
`timescale 1ns/1ns
module osc_axil_slave
   import osc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [31:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [31:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   output osc_pkg::osc_wr_s wr,
   input wire logic wr_ok,
   output logic [osc_pkg::ADDR_W-1:0] rd_addr,
   input wire logic rd_ok,
   input wire logic [31:0] rd_data
);
   import osc_pkg::*;

   logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
   logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic do_wr;

   // address and data are caught separately so either may come first
   assign s_awready = !aw_full_r;
   assign s_wready = !w_full_r;
   assign s_arready = !rvalid_r;
   assign do_wr = aw_full_r && w_full_r && !bvalid_r;
   assign rd_addr = s_araddr[ADDR_W-1:0];
   assign wr = '{en: do_wr, addr: awaddr_r, data: wdata_r, strb: wstrb_r};
   assign s_bvalid = bvalid_r;
   assign s_bresp = bresp_r;
   assign s_rvalid = rvalid_r;
   assign s_rresp = rresp_r;
   assign s_rdata = rdata_r;

   // next state of both channels
   always_comb
   begin
      aw_full_nxt = aw_full_r;
      w_full_nxt = w_full_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      if (s_awvalid && !aw_full_r)
      begin
         aw_full_nxt = 1'b1;
         awaddr_nxt = s_awaddr[ADDR_W-1:0];
      end
      if (s_wvalid && !w_full_r)
      begin
         w_full_nxt = 1'b1;
         wdata_nxt = s_wdata;
         wstrb_nxt = s_wstrb;
      end
      if (do_wr)
      begin
         aw_full_nxt = 1'b0;
         w_full_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && s_bready)
         bvalid_nxt = 1'b0;
      if (s_arvalid && !rvalid_r)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt = rd_ok ? RESP_OKAY : RESP_SLVERR;
         rdata_nxt = rd_data;
      end
      else if (rvalid_r && s_rready)
         rvalid_nxt = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= '0;
      end
      else
      begin
         aw_full_r <= aw_full_nxt;
         w_full_r <= w_full_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
      end
   end
endmodule

/* File: core/osc_switch_seq.sv */
// clock switch sequencer: holds a request to the oscillator side until acknowledged
// assumes sw_ack is a one-cycle pulse from the clock-source multiplexer
`timescale 1ns/1ns
module osc_switch_seq
   import osc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic sw_ack,
   output logic busy,
   output logic done
);
   import osc_pkg::*;

   osc_sw_e state_r, state_nxt;

   // request stays up until the far side reports the new source running
   always_comb
   begin
      state_nxt = state_r;
      done = 1'b0;
      unique case (state_r)
         SW_IDLE:
            if (start)
               state_nxt = SW_BUSY;
         SW_BUSY:
            if (sw_ack)
            begin
               state_nxt = SW_IDLE;
               done = 1'b1;
            end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         state_r <= SW_IDLE;
      else
         state_r <= state_nxt;
   end

   assign busy = (state_r == SW_BUSY);
endmodule

/* File: core/osc_ctrl.sv */
// oscillator control and status register with switch sequencing and interrupts
// assumes configuration straps are static after reset and status inputs are
// synchronous to clk
`timescale 1ns/1ns

// Overview of operation
// - monitor on and lock set: selections frozen
// - monitor on, lock clear: switching allowed
// - monitor off: never locked, switching allowed
// - lock status one when locked or timer done
// - lock status zero when unlocked, counting, disabled
// - lock status forced zero during switch, non-pll
// - fail flag set on detected clock failure
// - drive bit one forces high-power oscillator
// - drive bit ignored for digital clock input
// - enable bit runs secondary 32 kHz oscillator
// - writing switch enable moves to new source
// - switch enable clears when switch finishes
// - unimplemented bits ignore writes, read zero
module osc_ctrl
   import osc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [31:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [31:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire logic monitor_config_bit,
   input wire logic secondary_osc_source_cfg,
   input wire logic secondary_osc_power_cfg,
   input wire logic [osc_pkg::SRC_W-1:0] initial_source_cfg,
   input wire osc_pkg::osc_stat_s stat,
   input wire logic switch_ack,
   output logic switch_req,
   output logic [osc_pkg::SRC_W-1:0] switch_source,
   output logic pll_enable,
   output logic secondary_osc_run,
   output logic secondary_osc_high_power,
   output logic irq
);
   import osc_pkg::*;

   // true when the selected source runs through the pll
   function automatic logic uses_pll(input logic [SRC_W-1:0] src);
      uses_pll = (src == SRC_PLL_A) || (src == SRC_PLL_B);
   endfunction

   osc_wr_s wr;
   logic [ADDR_W-1:0] rd_addr;
   logic wr_ok, rd_ok;
   logic [31:0] rd_data;
   logic sel_lock_r, sel_lock_nxt;
   logic secondary_oscillator_en_r, secondary_oscillator_en_nxt;
   logic secondary_oscillator_drv_r, secondary_oscillator_drv_nxt;
   logic fail_r, fail_nxt;
   logic [SRC_W-1:0] new_src_r, new_src_nxt;
   logic [SRC_W-1:0] cur_src_r, cur_src_nxt;
   logic pll_lock_r, pll_lock_nxt;
   logic [NUM_EVT-1:0] evt_stat_r, evt_stat_nxt;
   logic [NUM_EVT-1:0] evt_mask_r, evt_mask_nxt;
   logic [NUM_EVT-1:0] evt_set;
   logic locked, wr_ctrl, wr_stat, wr_mask, lo_en, hi_en;
   logic start, sw_busy, sw_done, pll_lock_now;
   logic [REG_W-1:0] ctrl_view;

   osc_axil_slave u_bus (
      .clk(clk),
      .reset(reset),
      .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_bresp(s_bresp),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .s_araddr(s_araddr),
      .s_arvalid(s_arvalid),
      .s_arready(s_arready),
      .s_rdata(s_rdata),
      .s_rresp(s_rresp),
      .s_rvalid(s_rvalid),
      .s_rready(s_rready),
      .wr(wr),
      .wr_ok(wr_ok),
      .rd_addr(rd_addr),
      .rd_ok(rd_ok),
      .rd_data(rd_data)
   );

   osc_switch_seq u_seq (
      .clk(clk),
      .reset(reset),
      .start(start),
      .sw_ack(switch_ack),
      .busy(sw_busy),
      .done(sw_done)
   );

   // address decode for the three words; anything else answers with an error
   assign wr_ctrl = wr.en && (wr.addr == OFS_CTRL);
   assign wr_stat = wr.en && (wr.addr == OFS_IRQ_STAT);
   assign wr_mask = wr.en && (wr.addr == OFS_IRQ_MASK);
   assign wr_ok = (wr.addr == OFS_CTRL) || (wr.addr == OFS_IRQ_STAT)
      || (wr.addr == OFS_IRQ_MASK);
   assign rd_ok = (rd_addr == OFS_CTRL) || (rd_addr == OFS_IRQ_STAT)
      || (rd_addr == OFS_IRQ_MASK);
   assign lo_en = wr_ctrl && wr.strb[0];
   assign hi_en = wr_ctrl && wr.strb[1];

   // the lock only counts while the clock monitor is configured on
   assign locked = monitor_config_bit && sel_lock_r;

   // a switch starts only from idle and never while locked
   assign start = lo_en && wr.data[B_SWITCH_EN] && !locked && !sw_busy;

   // raw lock status, qualified by pll in use and no switch under way
   assign pll_lock_now = stat.pll_enabled && (stat.pll_locked || stat.pll_timer_done)
      && uses_pll(cur_src_r) && !sw_busy;

   // control fields written by software
   always_comb
   begin
      sel_lock_nxt = sel_lock_r;
      secondary_oscillator_en_nxt = secondary_oscillator_en_r;
      secondary_oscillator_drv_nxt = secondary_oscillator_drv_r;
      new_src_nxt = new_src_r;
      if (lo_en)
      begin
         sel_lock_nxt = wr.data[B_SEL_LOCK];
         secondary_oscillator_en_nxt = wr.data[B_SECONDARY_OSCILLATOR_EN];
         secondary_oscillator_drv_nxt = wr.data[B_SECONDARY_OSCILLATOR_DRV];
      end
      // source field frozen while locked or mid-switch so the target cannot move
      if (hi_en && !locked && !sw_busy)
         new_src_nxt = wr.data[B_NEW_SRC_LO +: SRC_W];
   end

   // current source follows the target once the far side acknowledges
   always_comb
   begin
      cur_src_nxt = cur_src_r;
      if (sw_done)
         cur_src_nxt = new_src_r;
   end

   // failure flag: hardware set beats a software clear in the same cycle
   always_comb
   begin
      fail_nxt = fail_r;
      if (lo_en && !wr.data[B_CLK_FAIL])
         fail_nxt = 1'b0;
      if (stat.fail_detect)
         fail_nxt = 1'b1;
   end

   always_comb
   begin
      pll_lock_nxt = pll_lock_now;
   end

   // sticky event bits, write one to clear, set wins over clear
   assign evt_set[E_SW_DONE] = sw_done;
   assign evt_set[E_CLK_FAIL] = stat.fail_detect && !fail_r;
   assign evt_set[E_PLL_LOCK] = pll_lock_now && !pll_lock_r;

   always_comb
   begin
      evt_stat_nxt = evt_stat_r;
      evt_mask_nxt = evt_mask_r;
      if (wr_stat && wr.strb[0])
         evt_stat_nxt = evt_stat_r & ~wr.data[NUM_EVT-1:0];
      evt_stat_nxt = evt_stat_nxt | evt_set;
      if (wr_mask && wr.strb[0])
         evt_mask_nxt = wr.data[NUM_EVT-1:0];
   end

   // the initial source strap is taken at reset, which is synchronous here
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sel_lock_r <= 1'b0;
         secondary_oscillator_en_r <= 1'b0;
         secondary_oscillator_drv_r <= 1'b0;
         fail_r <= 1'b0;
         new_src_r <= initial_source_cfg;
         cur_src_r <= initial_source_cfg;
         pll_lock_r <= 1'b0;
         evt_stat_r <= EVT_RESET;
         evt_mask_r <= EVT_RESET;
      end
      else
      begin
         sel_lock_r <= sel_lock_nxt;
         secondary_oscillator_en_r <= secondary_oscillator_en_nxt;
         secondary_oscillator_drv_r <= secondary_oscillator_drv_nxt;
         fail_r <= fail_nxt;
         new_src_r <= new_src_nxt;
         cur_src_r <= cur_src_nxt;
         pll_lock_r <= pll_lock_nxt;
         evt_stat_r <= evt_stat_nxt;
         evt_mask_r <= evt_mask_nxt;
      end
   end

   // register view; bits not assigned stay zero
   always_comb
   begin
      ctrl_view = '0;
      ctrl_view[B_SWITCH_EN] = sw_busy;
      ctrl_view[B_SECONDARY_OSCILLATOR_EN] = secondary_oscillator_en_r;
      ctrl_view[B_SECONDARY_OSCILLATOR_DRV] = secondary_oscillator_drv_r;
      ctrl_view[B_CLK_FAIL] = fail_r;
      // registered lock lags by a cycle, so mask it the moment a switch begins
      ctrl_view[B_PLL_LOCK] = pll_lock_r && !sw_busy;
      ctrl_view[B_SEL_LOCK] = sel_lock_r;
      ctrl_view[B_NEW_SRC_LO +: SRC_W] = new_src_r;
      ctrl_view[B_CUR_SRC_LO +: SRC_W] = cur_src_r;
   end

   always_comb
   begin
      rd_data = '0;
      unique case (rd_addr)
         OFS_CTRL: rd_data[REG_W-1:0] = ctrl_view;
         OFS_IRQ_STAT: rd_data[NUM_EVT-1:0] = evt_stat_r;
         OFS_IRQ_MASK: rd_data[NUM_EVT-1:0] = evt_mask_r;
         default: rd_data = '0;
      endcase
   end

   // outputs toward the oscillators and pll
   assign switch_req = sw_busy;
   assign switch_source = new_src_r;
   assign pll_enable = uses_pll(cur_src_r);
   assign secondary_osc_run = secondary_oscillator_en_r;
   // a digital clock input has no drive stage, so drive choice is moot there
   assign secondary_osc_high_power = secondary_osc_source_cfg
      && (secondary_oscillator_drv_r || secondary_osc_power_cfg);
   assign irq = |(evt_stat_r & evt_mask_r);
endmodule

/* File: verif/osc_ctrl_monitor.sv */
// checker of the oscillator control block, bound to its top module
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ns
module osc_ctrl_monitor
   import osc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic s_bvalid,
   input wire logic s_rvalid,
   input wire logic s_arready,
   input wire logic secondary_osc_source_cfg,
   input wire logic secondary_osc_power_cfg,
   input wire logic secondary_osc_high_power,
   input wire logic secondary_osc_run,
   input wire logic switch_ack,
   input wire logic switch_req,
   input wire logic [osc_pkg::SRC_W-1:0] switch_source,
   input wire logic pll_enable
);
   import osc_pkg::*;

   // one domain, so clock and reset are given once for every check
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   chk_hp_digital: assert property (
      !secondary_osc_source_cfg |-> !secondary_osc_high_power)
      else $error("high power chosen for a digital clock input");
   chk_hp_config: assert property (
      secondary_osc_source_cfg && secondary_osc_power_cfg |-> secondary_osc_high_power)
      else $error("high power configuration not honoured");
   chk_req_clear: assert property (
      switch_req && switch_ack |=> !switch_req)
      else $error("switch request stays after acknowledge");
   chk_req_hold: assert property (
      switch_req && !switch_ack |=> switch_req)
      else $error("switch request dropped before acknowledge");
   chk_src_steady: assert property (
      switch_req ##1 switch_req |-> $stable(switch_source))
      else $error("target source moved during a switch");
   chk_pll_moves: assert property (
      $changed(pll_enable) |-> $past(switch_ack) && $past(switch_req))
      else $error("pll selection changed without a finished switch");
   chk_req_start: assert property (
      $rose(switch_req) |-> s_bvalid || $past(s_bvalid))
      else $error("switch started without a register write");
   chk_run_write: assert property (
      $changed(secondary_osc_run) |-> s_bvalid || $past(s_bvalid))
      else $error("secondary oscillator run changed without a write");
   chk_ar_block: assert property (
      s_rvalid |-> !s_arready)
      else $error("read address accepted while data is pending");

   cover property ($rose(switch_req));
   cover property (switch_req && switch_ack);
   cover property ($rose(secondary_osc_run));
endmodule

bind osc_ctrl osc_ctrl_monitor u_mon (.clk, .reset, .s_bvalid, .s_rvalid, .s_arready,
   .secondary_osc_source_cfg, .secondary_osc_power_cfg, .secondary_osc_high_power,
   .secondary_osc_run, .switch_ack, .switch_req, .switch_source, .pll_enable);

/* File: verif/osc_far_model.sv */
// far side: clock multiplexer acknowledge plus pll and monitor status
// assumes the bench sets the acknowledge delay and the status levels
`timescale 1ns/1ns
module osc_far_model
   import osc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic switch_req,
   input wire logic pll_enable,
   input wire logic [3:0] delay,
   input wire logic lock_in,
   input wire logic timer_in,
   input wire logic fail_in,
   output logic switch_ack,
   output osc_pkg::osc_stat_s stat
);
   import osc_pkg::*;

   logic [4:0] cnt_r;
   logic done_r;

   // a stopped pll reports neither lock nor timer expiry
   assign stat = '{pll_enabled: pll_enable, pll_locked: lock_in & pll_enable,
                   pll_timer_done: timer_in & pll_enable, fail_detect: fail_in};

   // one pulse per request; a zero delay answers in the request cycle
   assign switch_ack = switch_req && !done_r && cnt_r == {1'b0, delay};

   always_ff @(posedge clk)
   begin
      if (reset || !switch_req)
      begin
         cnt_r <= 5'h00;
         done_r <= 1'b0;
      end
      else if (switch_ack)
         done_r <= 1'b1;
      else
         cnt_r <= cnt_r + 5'h01;
   end
endmodule

/* File: verif/test_oscillator_control_status.sv */
// self-checking bench of the oscillator control block
// assumes the far-side model and the bound checker beside it
`timescale 1ns/1ns
module test_oscillator_control_status;
   import osc_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [31:0] s_awaddr = '0, s_wdata = '0, s_araddr = '0, s_rdata, v;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0, s_bready = 1'b1, s_rready = 1'b1;
   logic [3:0] s_wstrb = 4'hF, delay = 4'h0;
   logic monitor_config_bit = 1'b1, secondary_osc_source_cfg = 1'b0;
   logic secondary_osc_power_cfg = 1'b0, lock_in = 1'b0, timer_in = 1'b0, fail_in = 1'b0;
   logic [2:0] initial_source_cfg = 3'h2, switch_source, nsrc, csrc, st, msk;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, switch_ack, switch_req;
   logic pll_enable, secondary_osc_run, secondary_osc_high_power, irq;
   logic en, drv, lk_sel, cf, busy, pl_q;
   logic [1:0] s_bresp, s_rresp, r;
   osc_stat_s stat;
   int failures = 0, n_compared = 0, i;

   always #2 clk = ~clk;

   osc_ctrl dut (.clk, .reset, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
      .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
      .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .monitor_config_bit,
      .secondary_osc_source_cfg, .secondary_osc_power_cfg, .initial_source_cfg, .stat,
      .switch_ack, .switch_req, .switch_source, .pll_enable, .secondary_osc_run,
      .secondary_osc_high_power, .irq);
   osc_far_model far (.clk, .reset, .switch_req, .pll_enable, .delay, .lock_in,
      .timer_in, .fail_in, .switch_ack, .stat);

   task automatic finish_test();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // bounded waits only: a hung handshake counts as a mismatch
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad, wd;
      int n;
      ad = 1'b0;
      wd = 1'b0;
      s_awaddr <= {28'h0, a};
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      n = 0;
      // edge first: a response from the previous write still stands in this time step
      do
      begin
         @(posedge clk);
         if (!ad && s_awready) begin ad = 1'b1; s_awvalid <= 1'b0; end
         if (!wd && s_wready) begin wd = 1'b1; s_wvalid <= 1'b0; end
         n++;
      end
      while (n < 50 && !s_bvalid);
      check("bresp", s_bresp, er);
      if (!s_bvalid) begin failures++; finish_test(); end
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rr);
      logic t;
      int n;
      t = 1'b0;
      s_araddr <= {28'h0, a};
      s_arvalid <= 1'b1;
      n = 0;
      // edge first so back-to-back reads never take the last read's data again
      do
      begin
         @(posedge clk);
         if (!t && s_arready) begin t = 1'b1; s_arvalid <= 1'b0; end
         n++;
      end
      while (n < 50 && !s_rvalid);
      d = s_rdata;
      rr = s_rresp;
      if (!s_rvalid) begin failures++; finish_test(); end
   endtask

   task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
      rd(a, v, r);
      check("rdata", v, exp);
      check("rresp", r, er);
   endtask

   // expected control word; the lock event is sticky on a rising lock bit
   function automatic logic [31:0] ctrl_x();
      logic pl;
      pl = (csrc == 3'h1 || csrc == 3'h3) && (lock_in || timer_in) && !busy;
      if (pl && !pl_q) st[E_PLL_LOCK] = 1'b1;
      pl_q = pl;
      return {17'h0, csrc, 1'b0, nsrc, lk_sel, 1'b0, pl, 1'b0, cf, drv, en, busy};
   endfunction

   function automatic logic [15:0] cur_w();
      return {5'h0, nsrc, lk_sel, 3'h0, cf, drv, en, 1'b0};
   endfunction

   task automatic chk_all();
      rdc(OFS_CTRL, ctrl_x(), RESP_OKAY);
      rdc(OFS_IRQ_STAT, {29'h0, st}, RESP_OKAY);
      rdc(OFS_IRQ_MASK, {29'h0, msk}, RESP_OKAY);
      check("run", secondary_osc_run, en);
      check("hp", secondary_osc_high_power, secondary_osc_source_cfg && (drv || secondary_osc_power_cfg));
      check("irq", irq, |(st & msk));
      check("pll", pll_enable, csrc == 3'h1 || csrc == 3'h3);
      check("req", switch_req, busy);
   endtask

   // a locked or busy write leaves source and switch state untouched
   task automatic wctl(input logic [15:0] d);
      logic locked;
      locked = monitor_config_bit && lk_sel;
      wr(OFS_CTRL, {16'h0, d}, RESP_OKAY);
      en = d[1];
      drv = d[2];
      if (!d[3]) cf = 1'b0;
      if (!locked && !busy) begin nsrc = d[10:8]; busy = d[0]; end
      if (busy) pl_q = 1'b0;
      lk_sel = d[7];
   endtask

   task automatic do_switch(input logic [2:0] s, input logic [3:0] d);
      int n;
      delay <= d;
      wctl({5'h0, s, lk_sel, 3'h0, cf, drv, en, 1'b1});
      if (busy && d > 4'h9)
      begin
         rdc(OFS_CTRL, ctrl_x(), RESP_OKAY);
         check("target", switch_source, s);
      end
      for (n = 0; n < 40 && busy; n++)
      begin
         rd(OFS_CTRL, v, r);
         if (!v[0]) begin busy = 1'b0; csrc = nsrc; st[E_SW_DONE] = 1'b1; end
      end
      if (busy) begin failures++; finish_test(); end
      chk_all;
   endtask

   task automatic do_reset(input logic m);
      reset <= 1'b1;
      monitor_config_bit <= m;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      {en, drv, lk_sel, cf, busy, pl_q, st, msk} = '0;
      csrc = 3'h2;
      nsrc = 3'h2;
   endtask

   initial
   begin
      void'($urandom(65));
      do_reset(1'b1);
      chk_all;
      rdc(4'hC, 32'h0, RESP_SLVERR);
      for (i = 0; i < 8; i++)
      begin
         secondary_osc_source_cfg <= i[0];
         secondary_osc_power_cfg <= i[1];
         wctl(16'($urandom) & 16'hFF7E);
         chk_all;
      end
      wr(OFS_IRQ_MASK, 32'h7, RESP_OKAY);
      msk = 3'h7;
      fail_in <= 1'b1;
      @(posedge clk);
      fail_in <= 1'b0;
      cf = 1'b1;
      st[E_CLK_FAIL] = 1'b1;
      chk_all;
      wctl(cur_w() & 16'hFFF7);
      wr(OFS_IRQ_STAT, 32'h2, RESP_OKAY);
      st[E_CLK_FAIL] = 1'b0;
      chk_all;
      lock_in <= 1'b1;
      do_switch(3'h1, 4'hF);
      lock_in <= 1'b0;
      timer_in <= 1'b1;
      chk_all;
      timer_in <= 1'b0;
      @(posedge clk); // lock status is registered one cycle behind its inputs
      chk_all;
      lock_in <= 1'b1;
      do_switch(3'h2, 4'($urandom_range(0, 15)));
      wctl(cur_w() | 16'h0080);
      do_switch(3'h3, 4'h3);
      do_reset(1'b0);
      wctl(cur_w() | 16'h0080);
      do_switch(3'h3, 4'($urandom_range(0, 15)));
      wr(OFS_IRQ_STAT, 32'h7, RESP_OKAY);
      st = 3'h0;
      chk_all;
      finish_test();
   end
endmodule
